// File: include/pvsp_pkg.sv
/*
 Constants of the serial voice port: rates, frame codes, clock
 counts and reset values. Assumes a 50 MHz system clock.
*/
package pvsp_pkg;

    // --------------------------------------------------------------
    // Clocks
    // --------------------------------------------------------------
    localparam int unsigned CLK_HZ       = 50_000_000;
    localparam int unsigned BCLK_KHZ_MIN = 256;
    localparam int unsigned MCLK_FS_HZ   = 48_000;
    localparam int unsigned MCLK_RATIO   = 256;
    localparam int unsigned MCLK_HZ      = MCLK_RATIO * MCLK_FS_HZ;
    localparam int unsigned NCO_W        = 24;
    localparam logic [NCO_W-1:0] NCO_INC =
        NCO_W'(64'(MCLK_HZ) * (64'h1 << NCO_W) / 64'(CLK_HZ));
    localparam int unsigned DIV_W        = 7;
    localparam logic [DIV_W-1:0] HALF_M1_256 =
        DIV_W'(CLK_HZ / (2 * 1000 * BCLK_KHZ_MIN) - 1);
    localparam logic [DIV_W-1:0] HALF_M1_512 =
        DIV_W'(CLK_HZ / (2 * 1000 * (BCLK_KHZ_MIN << 1)) - 1);
    localparam logic [DIV_W-1:0] HALF_M1_1024 =
        DIV_W'(CLK_HZ / (2 * 1000 * (BCLK_KHZ_MIN << 2)) - 1);
    localparam logic [DIV_W-1:0] HALF_M1_2048 =
        DIV_W'(CLK_HZ / (2 * 1000 * (BCLK_KHZ_MIN << 3)) - 1);

    // --------------------------------------------------------------
    // Codes and reset values
    // --------------------------------------------------------------
    localparam logic [1:0] RATE_256  = 2'h0;
    localparam logic [1:0] RATE_512  = 2'h1;
    localparam logic [1:0] RATE_1024 = 2'h2;
    localparam logic [1:0] RATE_2048 = 2'h3;
    localparam logic [2:0] FRM_8     = 3'h0;
    localparam logic [2:0] FRM_256   = 3'h5;
    localparam logic [8:0] FRM_BASE  = 9'h008;
    localparam int unsigned FS_KHZ_LO = 8;
    localparam int unsigned SAMPLE_W  = 16;
    localparam int unsigned SLOT_W    = 8;
    localparam logic [SLOT_W-1:0] LAST_BIT = 8'h0f;
    localparam logic [SLOT_W-1:0] SLOT_RST = 8'hff;
    localparam logic       MASTER_RST = 1'h1;
    localparam logic       LONG_RST   = 1'h0;
    localparam logic [1:0] RATE_RST   = RATE_2048;
    localparam logic [2:0] FRM_RST    = FRM_256;
    localparam logic       FS16_RST   = 1'h0;

endpackage : pvsp_pkg

// File: core/pvsp_sync2.sv
/*
 Two flip-flop level synchroniser, W bits wide.
 Assumes each bit is quasi-static or a toggle.
*/
`timescale 1ns/10ps
module pvsp_sync2 #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] q;
    } pvsp_sync_t;

    pvsp_sync_t s_q;
    pvsp_sync_t s_d;

    always_comb
    begin
        s_d.meta = d;
        s_d.q    = s_q.meta;
    end

    always_ff @(posedge clk)
    begin
        s_q <= s_d;
    end

    assign q = s_q.q;
endmodule : pvsp_sync2

// File: core/pvsp_buf2.sv
/*
 Small FIFO with valid and ready on both sides.
 Assumes both sides run on clk; DEPTH is a power of two.
*/
`timescale 1ns/10ps
module pvsp_buf2 #(
    parameter int W     = 16,
    parameter int DEPTH = 2
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         in_valid,
    input  wire logic [W-1:0] in_data,
    output logic              in_ready,
    output logic              out_valid,
    output logic      [W-1:0] out_data,
    input  wire logic         out_ready
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
    begin : g_chk
        $error("pvsp_buf2: DEPTH must be a power of two of 2 or more");
    end

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0]           wr;
        logic [AW-1:0]           rd;
        logic [AW:0]             cnt;
        logic                    full;
        logic                    empty;
    } pvsp_buf_t;

    pvsp_buf_t b_q;
    pvsp_buf_t b_d;
    logic      push;
    logic      pop;

    always_comb
    begin
        b_d  = b_q;
        push = in_valid && !b_q.full;
        pop  = out_ready && !b_q.empty;
        if (push)
        begin
            b_d.mem[b_q.wr] = in_data;
            b_d.wr          = b_q.wr + 1'b1;
        end
        if (pop)
        begin
            b_d.rd = b_q.rd + 1'b1;
        end
        b_d.cnt   = b_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
        b_d.full  = (b_d.cnt == (AW+1)'(DEPTH));
        b_d.empty = (b_d.cnt == '0);
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            b_q       <= '0;
            b_q.empty <= 1'b1;
        end
        else
        begin
            b_q <= b_d;
        end
    end

    assign in_ready  = !b_q.full;
    assign out_valid = !b_q.empty;
    assign out_data  = b_q.mem[b_q.rd];
endmodule : pvsp_buf2

// File: core/pvsp_top.sv
/*
 Serial voice port: clock and master clock generation, frame
 timing, shifting and word crossings to the user side.
 Assumes link_clk is the bit clock pin level in either role.
*/
`timescale 1ns/10ps
module pvsp_top
    import pvsp_pkg::*;
(
    input  wire logic                clk_sys,
    input  wire logic                rst,
    input  wire logic                link_clk,
    input  wire logic                cfg_load,
    input  wire logic                cfg_master,
    input  wire logic                cfg_long_sync,
    input  wire logic [1:0]          cfg_rate,
    input  wire logic [2:0]          cfg_frame,
    input  wire logic                cfg_fs16,
    input  wire logic                flag_clr,
    input  wire logic                tx_valid,
    input  wire logic [SAMPLE_W-1:0] tx_data,
    output logic                     tx_ready,
    output logic                     rx_valid,
    output logic      [SAMPLE_W-1:0] rx_data,
    input  wire logic                rx_ready,
    output logic                     cfg_ok,
    output logic                     underrun,
    output logic                     overrun,
    output logic                     bclk_o,
    output logic                     bclk_oe,
    output logic                     mclk_o,
    input  wire logic                frame_sync_pin_i,
    output logic                     frame_sync_pin_o,
    output logic                     frame_sync_pin_oe,
    input  wire logic                din,
    output logic                     dout_o,
    output logic                     dout_oe
);
    // --------------------------------------------------------------
    // State types
    // --------------------------------------------------------------
    typedef struct packed {
        logic                master;
        logic                long_sync;
        logic [1:0]          rate;
        logic [2:0]          frame;
        logic                fs16;
        logic [DIV_W-1:0]    div;
        logic                bclk;
        logic                bclk_oe;
        logic [NCO_W-1:0]    acc;
        logic                mclk;
        logic [SAMPLE_W-1:0] tx_word;
        logic                frm_seen;
        logic                rx_seen;
        logic                cfg_ok;
        logic                underrun;
        logic                overrun;
    } pvsp_sys_t;

    typedef struct packed {
        logic [SLOT_W-1:0]   slot;
        logic                fs_prev;
        logic [SAMPLE_W-1:0] shift;
        logic                dout;
        logic                fsync;
        logic                fsync_oe;
        logic                frm_tgl;
    } pvsp_lpos_t;

    typedef struct packed {
        logic [SAMPLE_W-1:0] rx_sh;
        logic [SAMPLE_W-1:0] rx_word;
        logic                rx_tgl;
        logic                oe;
    } pvsp_lneg_t;

    pvsp_sys_t  s_q;
    pvsp_sys_t  s_d;
    pvsp_lpos_t lp_q;
    pvsp_lpos_t lp_d;
    pvsp_lneg_t ln_q;
    pvsp_lneg_t ln_d;

    // --------------------------------------------------------------
    // Crossings and buffers
    // --------------------------------------------------------------
    logic                lrst;
    logic [4:0]          lcfg;
    logic [1:0]          tgl_sync;
    logic                txb_valid;
    logic [SAMPLE_W-1:0] txb_data;
    logic                txb_pop;
    logic                rxb_ready;
    logic                rx_ev;
    logic                frm_ev;

    pvsp_sync2 #(.W(1)) u_lrst (
        .clk (link_clk),
        .d   (rst),
        .q   (lrst)
    );

    pvsp_sync2 #(.W(5)) u_lcfg (
        .clk (link_clk),
        .d   ({s_q.master, s_q.long_sync, s_q.frame}),
        .q   (lcfg)
    );

    pvsp_sync2 #(.W(2)) u_tgl (
        .clk (clk_sys),
        .d   ({lp_q.frm_tgl, ln_q.rx_tgl}),
        .q   (tgl_sync)
    );

    pvsp_buf2 #(.W(SAMPLE_W), .DEPTH(2)) u_txb (
        .clk       (clk_sys),
        .rst       (rst),
        .in_valid  (tx_valid),
        .in_data   (tx_data),
        .in_ready  (tx_ready),
        .out_valid (txb_valid),
        .out_data  (txb_data),
        .out_ready (txb_pop)
    );

    pvsp_buf2 #(.W(SAMPLE_W), .DEPTH(2)) u_rxb (
        .clk       (clk_sys),
        .rst       (rst),
        .in_valid  (rx_ev),
        .in_data   (ln_q.rx_word),
        .in_ready  (rxb_ready),
        .out_valid (rx_valid),
        .out_data  (rx_data),
        .out_ready (rx_ready)
    );

    // --------------------------------------------------------------
    // System domain
    // --------------------------------------------------------------
    logic [DIV_W-1:0] half_m1;
    logic [15:0]      rate_khz;
    logic [15:0]      fs_khz;
    logic [15:0]      frm_bits;

    always_comb
    begin
        s_d     = s_q;
        frm_ev  = (tgl_sync[1] != s_q.frm_seen);
        rx_ev   = (tgl_sync[0] != s_q.rx_seen);
        txb_pop = frm_ev;
        if (cfg_load)
        begin
            s_d.master    = cfg_master;
            s_d.long_sync = cfg_long_sync;
            s_d.rate      = cfg_rate;
            s_d.frame     = cfg_frame;
            s_d.fs16      = cfg_fs16;
        end
        case (s_q.rate)
            RATE_256:  half_m1 = HALF_M1_256;
            RATE_512:  half_m1 = HALF_M1_512;
            RATE_1024: half_m1 = HALF_M1_1024;
            default:   half_m1 = HALF_M1_2048;
        endcase
        if (!s_q.master)
        begin
            s_d.div  = '0;
            s_d.bclk = 1'b0;
        end
        else if (s_q.div == '0)
        begin
            s_d.div  = half_m1;
            s_d.bclk = !s_q.bclk;
        end
        else
        begin
            s_d.div = s_q.div - 1'b1;
        end
        s_d.bclk_oe = s_q.master;
        s_d.acc     = s_q.acc + NCO_INC;
        s_d.mclk    = s_d.acc[NCO_W-1];
        s_d.frm_seen = tgl_sync[1];
        s_d.rx_seen  = tgl_sync[0];
        if (frm_ev)
        begin
            s_d.tx_word = txb_valid ? txb_data : '0;
        end
        s_d.underrun = (s_q.underrun && !flag_clr)
                     || (frm_ev && !txb_valid);
        s_d.overrun  = (s_q.overrun && !flag_clr)
                     || (rx_ev && !rxb_ready);
        rate_khz = 16'(BCLK_KHZ_MIN) << s_q.rate;
        fs_khz   = 16'(FS_KHZ_LO) << s_q.fs16;
        frm_bits = 16'(FRM_BASE) << s_q.frame;
        s_d.cfg_ok = (rate_khz == 16'(fs_khz * frm_bits))
                   && (s_q.frame <= FRM_256);
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            s_q           <= '0;
            s_q.master    <= MASTER_RST;
            s_q.long_sync <= LONG_RST;
            s_q.rate      <= RATE_RST;
            s_q.frame     <= FRM_RST;
            s_q.fs16      <= FS16_RST;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // --------------------------------------------------------------
    // Link domain, rising edge
    // --------------------------------------------------------------
    logic [SLOT_W-1:0] len_m1;
    logic [SLOT_W-1:0] half;
    logic [SLOT_W-1:0] slot_nx;
    logic              l_master;
    logic              l_long;

    always_comb
    begin
        lp_d     = lp_q;
        l_master = lcfg[4];
        l_long   = lcfg[3];
        len_m1   = SLOT_W'((FRM_BASE << lcfg[2:0]) - 9'h001);
        half     = SLOT_W'((FRM_BASE << lcfg[2:0]) >> 1);
        slot_nx  = (lp_q.slot == len_m1) ? '0 : lp_q.slot + 1'b1;
        lp_d.fs_prev = frame_sync_pin_i;
        if (!l_master && frame_sync_pin_i && !lp_q.fs_prev)
        begin
            slot_nx = 8'h01;
        end
        lp_d.slot = slot_nx;
        if (slot_nx == '0)
        begin
            lp_d.shift   = s_q.tx_word;
            lp_d.dout    = s_q.tx_word[SAMPLE_W-1];
            lp_d.frm_tgl = !lp_q.frm_tgl;
        end
        else if (slot_nx <= LAST_BIT)
        begin
            lp_d.shift = lp_q.shift << 1;
            lp_d.dout  = lp_q.shift[SAMPLE_W-2];
        end
        lp_d.fsync_oe = l_master;
        if (l_long)
        begin
            lp_d.fsync = l_master && (slot_nx < half)
                       && (slot_nx == '0 || lp_q.fsync);
        end
        else
        begin
            lp_d.fsync = l_master && (slot_nx == '0);
        end
    end

    always_ff @(posedge link_clk)
    begin
        if (lrst)
        begin
            lp_q      <= '0;
            lp_q.slot <= SLOT_RST;
        end
        else
        begin
            lp_q <= lp_d;
        end
    end

    // --------------------------------------------------------------
    // Link domain, falling edge
    // --------------------------------------------------------------
    always_comb
    begin
        ln_d = ln_q;
        if (lp_q.slot <= LAST_BIT)
        begin
            ln_d.rx_sh = {ln_q.rx_sh[SAMPLE_W-2:0], din};
        end
        if (lp_q.slot == LAST_BIT)
        begin
            ln_d.rx_word = ln_d.rx_sh;
            ln_d.rx_tgl  = !ln_q.rx_tgl;
        end
        ln_d.oe = (lp_q.slot < LAST_BIT)
                || (lp_q.slot == len_m1);
    end

    always_ff @(negedge link_clk)
    begin
        if (lrst)
        begin
            ln_q <= '0;
        end
        else
        begin
            ln_q <= ln_d;
        end
    end

    // --------------------------------------------------------------
    // Outputs
    // --------------------------------------------------------------
    assign cfg_ok            = s_q.cfg_ok;
    assign underrun          = s_q.underrun;
    assign overrun           = s_q.overrun;
    assign bclk_o            = s_q.bclk;
    assign bclk_oe           = s_q.bclk_oe;
    assign mclk_o            = s_q.mclk;
    assign frame_sync_pin_o  = lp_q.fsync;
    assign frame_sync_pin_oe = lp_q.fsync_oe;
    assign dout_o            = lp_q.dout;
    assign dout_oe           = ln_q.oe;

    // --------------------------------------------------------------
    // Checks
    // --------------------------------------------------------------
    logic [SLOT_W:0] hi_run;

    always_ff @(posedge link_clk)
    begin
        if (lrst)
        begin
            hi_run <= '0;
        end
        else
        begin
            hi_run <= lp_q.fsync ? hi_run + 1'b1 : '0;
        end
    end

    short_sync_a: assert property (@(posedge link_clk) disable iff (lrst)
        lp_q.fsync && !l_long |=> !lp_q.fsync)
        else $error("short sync wider than one bit clock");
    sync_slot_a: assert property (@(posedge link_clk) disable iff (lrst)
        $rose(lp_q.fsync) |-> lp_q.slot == '0)
        else $error("frame sync not at slot zero");
    long_sync_a: assert property (@(posedge link_clk) disable iff (lrst)
        l_master && l_long && $fell(lp_q.fsync)
        |-> hi_run == {1'b0, half})
        else $error("long sync high time not half a frame");
    pad_off_a: assert property (@(posedge link_clk) disable iff (lrst)
        lp_q.slot > LAST_BIT && lp_q.slot < len_m1
        |-> !dout_oe)
        else $error("data output driven past sample bits");
    release_a: assert property (@(negedge link_clk) disable iff (lrst)
        $fell(ln_q.oe) |-> $past(lp_q.slot) == LAST_BIT)
        else $error("data output released at wrong slot");
    msb_first_a: assert property (@(posedge link_clk) disable iff (lrst)
        lp_q.slot == '0 |-> lp_q.dout == lp_q.shift[SAMPLE_W-1])
        else $error("first slot does not carry the MSB");
    bit_launch_a: assert property (@(posedge link_clk) disable iff (lrst)
        lp_q.slot > '0 && lp_q.slot <= LAST_BIT && $past(lp_q.slot) != '1
        |-> lp_q.dout == $past(lp_q.shift[SAMPLE_W-2]))
        else $error("output bit not shifted in order");
    rx_word_a: assert property (@(negedge link_clk) disable iff (lrst)
        $changed(ln_q.rx_tgl) |-> $past(lp_q.slot) == LAST_BIT)
        else $error("receive word closed at wrong slot");
    bclk_half_a: assert property (@(posedge clk_sys) disable iff (rst)
        s_q.master && $changed(s_q.bclk) && $stable(s_q.rate)
        |-> s_q.div == half_m1)
        else $error("bit clock half period wrong");
    mclk_rate_a: assert property (@(posedge clk_sys) disable iff (rst)
        $changed(s_q.mclk) |-> ##1 $stable(s_q.mclk)
        ##[1:2] $changed(s_q.mclk))
        else $error("master clock half period out of range");
    fs_match_a: assert property (@(posedge clk_sys) disable iff (rst)
        s_q.cfg_ok && $past(s_q.rate) == RATE_2048 && !$past(s_q.fs16)
        |-> $past(s_q.frame) == FRM_256)
        else $error("frame check accepts wrong frame size");

    short_frame_c: cover property (@(posedge link_clk) disable iff (lrst)
        l_master && !l_long && $rose(lp_q.fsync));
    long_frame_c: cover property (@(posedge link_clk) disable iff (lrst)
        l_master && l_long && $fell(lp_q.fsync));
    rx_word_c: cover property (@(posedge clk_sys) disable iff (rst)
        rx_valid && rx_ready);
    underrun_c: cover property (@(posedge clk_sys) disable iff (rst)
        $rose(s_q.underrun));
endmodule : pvsp_top

// File: testbench/pvsp_codec_model.sv
/*
 Behavioural codec on the far side of the voice link.
 Assumes the bench resolves the bit clock, sync and data wires.
*/
`timescale 1ns/10ps
module pvsp_codec_model (
    input  wire logic        bclk,
    input  wire logic        fs_w,
    input  wire logic        dout_w,
    input  wire logic        dout_oe,
    input  wire logic [8:0]  frame_len,
    input  wire logic [15:0] send_word,
    input  wire logic        chk,
    output logic             din,
    output logic             fs_gen,
    output logic      [15:0] cap_word,
    output int               cap_cnt,
    output int               oe_bad
);
    logic [8:0]  slot    = 9'h000;
    logic [8:0]  gen_cnt = 9'h000;
    logic        fs_prev = 1'b0;
    logic [15:0] shreg   = 16'h0000;

    initial
    begin
        din      = 1'b0;
        fs_gen   = 1'b0;
        cap_word = 16'h0000;
        cap_cnt  = 0;
        oe_bad   = 0;
    end

    // ----------------------------
    // Rise: sync, launch, enable
    // ----------------------------
    always @(posedge bclk)
    begin
        if (fs_w && !fs_prev)
            slot = 9'h001;
        else
            slot = (slot == frame_len - 9'h001) ? 9'h000 : slot + 9'h001;
        fs_prev = fs_w;
        if (slot < 9'h010)
            din <= send_word[4'hf - slot[3:0]];
        else
            din <= ~din;
        if (chk && ((slot < 9'h010) !== dout_oe))
            oe_bad++;
        gen_cnt = (gen_cnt == frame_len - 9'h001) ? 9'h000 : gen_cnt + 9'h001;
        fs_gen <= (gen_cnt == 9'h000);
    end

    // ----------------------------
    // Fall: capture of the device word
    // ----------------------------
    always @(negedge bclk)
    begin
        if (slot < 9'h010)
            shreg = {shreg[14:0], dout_w};
        if (slot == 9'h00f)
        begin
            cap_word <= shreg;
            cap_cnt++;
        end
    end
endmodule : pvsp_codec_model

// File: testbench/testbench.sv
/*
 Self-checking bench of the voice port: clocks, frames, samples.
 Assumes the package, the design and the codec model compile first.
*/
`timescale 1ns/10ps
module testbench;
    import pvsp_pkg::*;
    // ----------------------------
    // Signals
    // ----------------------------
    logic        clk_sys = 1'b0, ext_clk = 1'b0, rst = 1'b1, use_ext = 1'b1;
    logic        cfg_load = 1'b0, cfg_master = 1'b1, cfg_long_sync = 1'b0;
    logic        cfg_fs16 = 1'b0, flag_clr = 1'b0, psel = 1'b0, chk = 1'b0;
    logic [1:0]  cfg_rate = RATE_2048;
    logic [2:0]  cfg_frame = FRM_256;
    logic        tx_valid = 1'b0, rx_ready = 1'b0, m0;
    logic [15:0] tx_data = 16'h0000, rx_data, cap_word;
    logic        tx_ready, rx_valid, cfg_ok, underrun, overrun, bclk_o;
    logic        bclk_oe, mclk_o, frame_sync_pin_o, frame_sync_pin_oe, din;
    logic        dout_o, dout_oe, fs_gen, link_clk, fs_w, dout_w, probe;
    logic [DIV_W-1:0] halfs [4] = '{HALF_M1_256, HALF_M1_512,
                                    HALF_M1_1024, HALF_M1_2048};
    int          miscompares = 0, comparisons = 0, cycles = 0;
    int          cap_cnt, oe_bad, n, hi, per, bit_t;

    assign link_clk = use_ext ? ext_clk : bclk_o;
    assign fs_w = frame_sync_pin_oe ? frame_sync_pin_o : fs_gen & !cfg_master;
    assign dout_w = dout_oe & dout_o;
    assign probe = psel ? fs_w : bclk_o;

    initial forever #10 clk_sys = ~clk_sys;
    initial
    begin
        #3;
        forever #16 ext_clk = ~ext_clk;
    end

    pvsp_top pvsp_top_i (.clk_sys, .rst, .link_clk, .cfg_load, .cfg_master,
        .cfg_long_sync, .cfg_rate, .cfg_frame, .cfg_fs16, .flag_clr,
        .tx_valid, .tx_data, .tx_ready, .rx_valid, .rx_data, .rx_ready,
        .cfg_ok, .underrun, .overrun, .bclk_o, .bclk_oe, .mclk_o,
        .frame_sync_pin_i(fs_w), .frame_sync_pin_o, .frame_sync_pin_oe,
        .din, .dout_o, .dout_oe);
    pvsp_codec_model pvsp_codec_model_i (.bclk(link_clk), .fs_w, .dout_w,
        .dout_oe, .frame_len(9'h020), .send_word(16'hb4e1), .chk, .din,
        .fs_gen, .cap_word, .cap_cnt, .oe_bad);

    // ----------------------------
    // Tasks
    // ----------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask : check

    task automatic test_done();
        $display("Counts: %0d comparisons, %0d miscompares",
                 comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : test_done

    task automatic tick(input int k);
        repeat (k) @(posedge clk_sys);
    endtask : tick

    task automatic set_cfg(input logic m, input logic l,
                           input logic [1:0] r, input logic [2:0] f,
                           input logic s);
        @(posedge clk_sys);
        cfg_master    <= m;
        cfg_long_sync <= l;
        cfg_rate      <= r;
        cfg_frame     <= f;
        cfg_fs16      <= s;
        cfg_load      <= 1'b1;
        @(posedge clk_sys);
        cfg_load      <= 1'b0;
        tick(3);
    endtask : set_cfg

    // High time and period of the probed pin, in system cycles
    task automatic measure();
        hi = 0;
        @(negedge clk_sys);
        while (probe) @(negedge clk_sys);
        while (!probe) @(negedge clk_sys);
        while (probe)
        begin
            hi++;
            @(negedge clk_sys);
        end
        per = hi;
        while (!probe)
        begin
            per++;
            @(negedge clk_sys);
        end
    endtask : measure

    task automatic write_word(input logic [15:0] w);
        @(negedge clk_sys);
        while (tx_ready !== 1'b1) @(negedge clk_sys);
        tx_valid <= 1'b1;
        tx_data  <= w;
        @(posedge clk_sys);
        tx_valid <= 1'b0;
    endtask : write_word

    task automatic read_word(input logic [15:0] exp);
        do @(negedge clk_sys); while (rx_valid !== 1'b1);
        check(rx_data, exp);
        rx_ready <= 1'b1;
        @(posedge clk_sys);
        rx_ready <= 1'b0;
    endtask : read_word

    task automatic wait_cap();
        n = cap_cnt;
        while (cap_cnt == n) @(negedge clk_sys);
    endtask : wait_cap

    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 90000)
        begin
            miscompares++;
            test_done();
        end
    end

    // ----------------------------
    // Sequence
    // ----------------------------
    initial
    begin
        bit_t = 2 * (int'(HALF_M1_2048) + 1);
        repeat (6) @(posedge clk_sys);
        rst     <= 1'b0;
        use_ext <= 1'b0;
        tick(4);
        check(cfg_ok, 1'b1);
        check({tx_ready, underrun, overrun, rx_valid}, 4'h8);
        measure();
        check(16'(per), 16'(bit_t));
        check({bclk_oe, frame_sync_pin_oe}, 2'h3);
        n = 0;
        repeat (1000)
        begin
            m0 = mclk_o;
            @(negedge clk_sys);
            n += int'(mclk_o && !m0);
        end
        check(16'(n - MCLK_HZ / 50_000 < 2), 16'h0001);
        for (int r = 0; r < 4; r++)
        begin
            set_cfg(1'b1, 1'b0, 2'(r), 3'h2, 1'b0);
            measure();
            measure();
            check(16'(per), 16'(2 * (int'(halfs[r]) + 1)));
        end
        $display("clock test ended");
        psel = 1'b1;
        for (int i = 0; i < 6; i++)
        begin
            set_cfg(1'b1, 1'b0, RATE_2048, 3'(i), i == 4);
            measure();
            measure();
            check(16'(hi), 16'(bit_t));
            check(16'(per), 16'(bit_t << (i + 3)));
            check(cfg_ok, 2048 == (i == 4 ? 16 : 8) * (8 << i));
        end
        $display("frame test ended");
        rx_ready <= 1'b1;
        set_cfg(1'b1, 1'b0, RATE_2048, 3'h2, 1'b0);
        tick(64 * bit_t);
        rx_ready <= 1'b0;
        chk = 1'b1;
        wait_cap();
        write_word(16'h9c3a);
        tick(1);
        write_word(16'h5e07);
        @(negedge clk_sys);
        check(tx_ready, 1'b0);
        while (cap_word === 16'h0000) wait_cap();
        check(cap_word, 16'h9c3a);
        wait_cap();
        check(cap_word, 16'h5e07);
        check({underrun, overrun}, 2'h3);
        read_word(16'hb4e1);
        read_word(16'hb4e1);
        flag_clr <= 1'b1;
        @(posedge clk_sys);
        flag_clr <= 1'b0;
        @(negedge clk_sys);
        check({underrun, overrun}, 2'h0);
        $display("data test ended");
        chk = 1'b0;
        rx_ready <= 1'b1;
        set_cfg(1'b1, 1'b1, RATE_2048, 3'h2, 1'b0);
        tick(64 * bit_t);
        rx_ready <= 1'b0;
        chk = 1'b1;
        measure();
        check(16'(hi), 16'(16 * bit_t));
        check(16'(per - hi), 16'(16 * bit_t));
        read_word(16'hb4e1);
        write_word(16'h0ff1);
        while (cap_word === 16'h0000) wait_cap();
        check(cap_word, 16'h0ff1);
        check(16'(oe_bad), 16'h0000);
        chk = 1'b0;
        set_cfg(1'b0, 1'b0, RATE_2048, 3'h2, 1'b0);
        use_ext <= 1'b1;
        tick(100);
        check({bclk_oe, frame_sync_pin_oe}, 2'h0);
        $display("long and slave test ended");
        test_done();
    end
endmodule : testbench
